//--- core/xbm_pkg.sv
// package: constants for the expansion bus master and arbitration block
`default_nettype none
package xbm_pkg;
	// cpu clock period figure
	localparam int CLK_PERIOD_NS = 20;
	// arbitration timing, in cpu clock periods as printed
	localparam int HOLD_TO_RELEASE_P = 3;
	localparam int RELEASE_TO_ACK_P = 2;
	localparam int DROP_TO_ACK_LOW_P = 3;
	localparam int ACK_LOW_TO_DRIVE_P = 2;
	// cycle counts derived from the figures (one p equals one cpu clock here)
	localparam int HOLD_TO_RELEASE_CYC = (HOLD_TO_RELEASE_P * CLK_PERIOD_NS + CLK_PERIOD_NS - 1)
		/ CLK_PERIOD_NS;
	localparam int RELEASE_TO_ACK_CYC = (RELEASE_TO_ACK_P * CLK_PERIOD_NS) / CLK_PERIOD_NS;
	localparam int DROP_TO_ACK_LOW_CYC = (DROP_TO_ACK_LOW_P * CLK_PERIOD_NS + CLK_PERIOD_NS - 1)
		/ CLK_PERIOD_NS;
	localparam int ACK_LOW_TO_DRIVE_CYC = (ACK_LOW_TO_DRIVE_P * CLK_PERIOD_NS) / CLK_PERIOD_NS;
	// widths
	localparam int BE_W = 4;
	localparam int CNT_W = 3;
	// byte enable idle value (active low, none enabled)
	localparam logic [3:0] BE_IDLE = 4'hF;
	// arbitration states
	typedef enum logic [2:0] {
		XBM_ARB_OWN = 3'h0,
		XBM_ARB_WAIT = 3'h1,
		XBM_ARB_FLOAT = 3'h2,
		XBM_ARB_HELD = 3'h3,
		XBM_ARB_DROP = 3'h4,
		XBM_ARB_RETAKE = 3'h5
	} xbm_arb_e;
	// link transfer states
	typedef enum logic [1:0] {
		XBM_LNK_IDLE = 2'h0,
		XBM_LNK_ADDR = 2'h1,
		XBM_LNK_DATA = 2'h2
	} xbm_lnk_e;
endpackage
`default_nettype wire

//--- core/xbm_sync2.sv
// two flip-flop level synchroniser, width parameterised
`default_nettype none
module xbm_sync2 #(
	parameter int W = 1
) (
	// clock and reset
	input wire logic clk_in,
	input wire logic rst_b_in,
	// level in and out
	input wire logic [W-1:0] d_in,
	output logic [W-1:0] q_out
);
	logic [W-1:0] meta_r;
	logic [W-1:0] q_r;

	// first stage feeds only the second
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			meta_r <= '0;
			q_r <= '0;
		end else begin
			meta_r <= d_in;
			q_r <= meta_r;
		end
	end
	assign q_out = q_r;
endmodule
`default_nettype wire

//--- core/xbm_master.sv
// expansion bus synchronous master with hold arbitration, answering an external hold request
`default_nettype none
module xbm_master (
	// cpu clock domain
	input wire logic ref_clk_in,
	input wire logic rst_b_in,
	// link clock
	input wire logic control_group_a_clock_in,
	// boot strap for direction polarity, 1 means high is write
	input wire logic dir_pol_strap_in,
	// user transfer request (cpu domain, level held until done)
	input wire logic req_in,
	input wire logic req_write_in,
	input wire logic [3:0] req_be_in,
	input wire logic req_last_in,
	output logic req_done_out,
	// arbitration pins
	input wire logic control_group_a_hold_request,
	output logic control_group_a_hold_ack,
	// control group pins with enables
	output logic [3:0] control_group_a_byte_enable_n,
	output logic control_group_a_addr_strobe_n,
	output logic control_group_a_write_read_dir,
	output logic control_group_a_burst_last,
	output logic ctl_oe_out,
	// ready pin, three signals
	input wire logic control_group_a_ready_n_in,
	output logic control_group_a_ready_n_out,
	output logic control_group_a_ready_n_oe_out,
	// wait output and back-off input
	output logic control_group_a_wait_out,
	input wire logic control_group_a_back_off
);
	// ************************************************************
	// cpu domain: synchronisers and strap capture
	// ************************************************************
	logic hold_s;
	logic dir_pol_r, dir_pol_nxt;
	logic strap_done_r, strap_done_nxt;
	logic busy_c;
	logic done_tog_c;
	logic done_tog_r, done_tog_nxt;
	logic lnk_done_tog_r, lnk_done_tog_nxt;
	logic lnk_idle_r, lnk_idle_nxt;
	logic lnk_idle_c;

	xbm_sync2 #(.W(1)) u_hold_sync (
		.clk_in(ref_clk_in),
		.rst_b_in(rst_b_in),
		.d_in(control_group_a_hold_request),
		.q_out(hold_s)
	);
	xbm_sync2 #(.W(1)) u_done_sync (
		.clk_in(ref_clk_in),
		.rst_b_in(rst_b_in),
		.d_in(lnk_done_tog_r),
		.q_out(done_tog_c)
	);

	// strap caught once after reset release
	always_comb begin
		dir_pol_nxt = dir_pol_r;
		strap_done_nxt = 1'b1;
		if (!strap_done_r) begin
			dir_pol_nxt = dir_pol_strap_in;
		end
		done_tog_nxt = done_tog_c;
	end
	always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			dir_pol_r <= 1'b1;
			strap_done_r <= 1'b0;
			done_tog_r <= 1'b0;
		end else begin
			dir_pol_r <= dir_pol_nxt;
			strap_done_r <= strap_done_nxt;
			done_tog_r <= done_tog_nxt;
		end
	end
	assign req_done_out = done_tog_c ^ done_tog_r;

	// ************************************************************
	// cpu domain: arbitration state machine
	// ************************************************************
	xbm_pkg::xbm_arb_e arb_r, arb_nxt;
	logic [xbm_pkg::CNT_W-1:0] cnt_r, cnt_nxt;
	logic ack_r, ack_nxt;
	logic own_r, own_nxt;
	logic go_r, go_nxt;
	logic grant_c;

	// busy while a request is outstanding and not yet finished
	assign busy_c = req_in & ~req_done_out;

	always_comb begin
		arb_nxt = arb_r;
		cnt_nxt = cnt_r;
		ack_nxt = ack_r;
		own_nxt = own_r;
		go_nxt = busy_c & grant_c;
		case (arb_r)
			xbm_pkg::XBM_ARB_OWN: begin
				cnt_nxt = '0;
				if (hold_s) begin
					arb_nxt = xbm_pkg::XBM_ARB_WAIT;
					cnt_nxt = 3'(1);
				end
			end
			xbm_pkg::XBM_ARB_WAIT: begin
				if (cnt_r < 3'(xbm_pkg::HOLD_TO_RELEASE_CYC)) begin
					cnt_nxt = cnt_r + 3'(1);
				end
				// float only when timed out and transfer finished
				if (cnt_r >= 3'(xbm_pkg::HOLD_TO_RELEASE_CYC) && !busy_c && lnk_idle_c) begin
					arb_nxt = xbm_pkg::XBM_ARB_FLOAT;
					own_nxt = 1'b0;
					cnt_nxt = '0;
				end
			end
			xbm_pkg::XBM_ARB_FLOAT: begin
				// acknowledge one cycle after the float
				arb_nxt = xbm_pkg::XBM_ARB_HELD;
				ack_nxt = 1'b1;
			end
			xbm_pkg::XBM_ARB_HELD: begin
				cnt_nxt = '0;
				if (!hold_s) begin
					arb_nxt = xbm_pkg::XBM_ARB_DROP;
					cnt_nxt = 3'(1);
				end
			end
			xbm_pkg::XBM_ARB_DROP: begin
				cnt_nxt = cnt_r + 3'(1);
				if (cnt_r >= 3'(xbm_pkg::DROP_TO_ACK_LOW_CYC)) begin
					arb_nxt = xbm_pkg::XBM_ARB_RETAKE;
					ack_nxt = 1'b0;
				end
			end
			xbm_pkg::XBM_ARB_RETAKE: begin
				arb_nxt = xbm_pkg::XBM_ARB_OWN;
				own_nxt = 1'b1;
			end
			default: begin
				arb_nxt = xbm_pkg::XBM_ARB_OWN;
				own_nxt = 1'b1;
				ack_nxt = 1'b0;
			end
		endcase
	end
	always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			arb_r <= xbm_pkg::XBM_ARB_OWN;
			cnt_r <= '0;
			ack_r <= 1'b0;
			own_r <= 1'b1;
			go_r <= 1'b0;
		end else begin
			arb_r <= arb_nxt;
			cnt_r <= cnt_nxt;
			ack_r <= ack_nxt;
			own_r <= own_nxt;
			go_r <= go_nxt;
		end
	end
	assign control_group_a_hold_ack = ack_r;
	assign ctl_oe_out = own_r;
	// new transfers start only while owning and no hold pending
	assign grant_c = own_r & (arb_r == xbm_pkg::XBM_ARB_OWN) & ~hold_s;

	// ************************************************************
	// link domain: synchronous master transfer
	// ************************************************************
	logic go_l, boff_l, rdy_l;
	xbm_pkg::xbm_lnk_e lnk_r, lnk_nxt;
	logic [3:0] be_r, be_nxt;
	logic as_r, as_nxt;
	logic dir_r, dir_nxt;
	logic blast_r, blast_nxt;
	logic wait_r, wait_nxt;
	logic pend_r, pend_nxt;

	xbm_sync2 #(.W(3)) u_lnk_sync (
		.clk_in(control_group_a_clock_in),
		.rst_b_in(rst_b_in),
		.d_in({go_r, control_group_a_back_off, ~control_group_a_ready_n_in}), // go is a register before it crosses
		.q_out({go_l, boff_l, rdy_l})
	);
	xbm_sync2 #(.W(1)) u_idle_sync (
		.clk_in(ref_clk_in),
		.rst_b_in(rst_b_in),
		.d_in(lnk_idle_r), // registered so no state decode glitch crosses
		.q_out(lnk_idle_c)
	);

	always_comb begin
		lnk_nxt = lnk_r;
		lnk_done_tog_nxt = lnk_done_tog_r;
		be_nxt = be_r;
		as_nxt = 1'b1;
		dir_nxt = dir_r;
		blast_nxt = 1'b1;
		wait_nxt = 1'b1; // wait inactive high while master
		pend_nxt = pend_r;
		case (lnk_r)
			xbm_pkg::XBM_LNK_IDLE: begin
				be_nxt = xbm_pkg::BE_IDLE;
				if (go_l && !pend_r && !boff_l) begin
					lnk_nxt = xbm_pkg::XBM_LNK_ADDR;
					as_nxt = 1'b0;
					be_nxt = ~req_be_in;
					dir_nxt = req_write_in ~^ dir_pol_r;
				end
				if (!go_l) begin
					pend_nxt = 1'b0;
				end
			end
			xbm_pkg::XBM_LNK_ADDR: begin
				lnk_nxt = xbm_pkg::XBM_LNK_DATA;
				blast_nxt = ~req_last_in;
			end
			xbm_pkg::XBM_LNK_DATA: begin
				blast_nxt = ~req_last_in;
				if (boff_l) begin
					lnk_nxt = xbm_pkg::XBM_LNK_IDLE;
					blast_nxt = 1'b1;
				end else if (rdy_l) begin
					// ready sampled active low
					lnk_nxt = xbm_pkg::XBM_LNK_IDLE;
					lnk_done_tog_nxt = ~lnk_done_tog_r;
					pend_nxt = 1'b1;
					blast_nxt = 1'b1;
				end
			end
			default: begin
				lnk_nxt = xbm_pkg::XBM_LNK_IDLE;
			end
		endcase
		lnk_idle_nxt = (lnk_nxt == xbm_pkg::XBM_LNK_IDLE);
	end
	always_ff @(posedge control_group_a_clock_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			lnk_r <= xbm_pkg::XBM_LNK_IDLE;
			lnk_done_tog_r <= 1'b0;
			be_r <= xbm_pkg::BE_IDLE;
			as_r <= 1'b1;
			dir_r <= 1'b0;
			blast_r <= 1'b1;
			wait_r <= 1'b1;
			pend_r <= 1'b0;
			lnk_idle_r <= 1'b1;
		end else begin
			lnk_r <= lnk_nxt;
			lnk_done_tog_r <= lnk_done_tog_nxt;
			be_r <= be_nxt;
			as_r <= as_nxt;
			dir_r <= dir_nxt;
			blast_r <= blast_nxt;
			wait_r <= wait_nxt;
			pend_r <= pend_nxt;
			lnk_idle_r <= lnk_idle_nxt;
		end
	end
	assign control_group_a_byte_enable_n = be_r;
	assign control_group_a_addr_strobe_n = as_r;
	assign control_group_a_write_read_dir = dir_r;
	assign control_group_a_burst_last = blast_r;
	assign control_group_a_wait_out = wait_r;
	// ready is an input while this end masters
	assign control_group_a_ready_n_out = 1'b1;
	assign control_group_a_ready_n_oe_out = 1'b0;

	// ************************************************************
	// assertions
	// ************************************************************
	sequence s_hold_seen;
		$rose(hold_s) && arb_r == xbm_pkg::XBM_ARB_OWN;
	endsequence
	property p_float_late;
		@(posedge ref_clk_in) disable iff (!rst_b_in)
		s_hold_seen |-> own_r [*3];
	endproperty
	a_float_late: assert property (p_float_late) else $error("bus floated too early");
	property p_ack_after_float;
		@(posedge ref_clk_in) disable iff (!rst_b_in)
		$fell(own_r) |-> ##[1:2] ack_r;
	endproperty
	a_ack_after_float: assert property (p_ack_after_float) else $error("ack late");
	property p_ack_floated;
		@(posedge ref_clk_in) disable iff (!rst_b_in)
		ack_r |-> !own_r;
	endproperty
	a_ack_floated: assert property (p_ack_floated) else $error("ack while driving");
	property p_ack_hold;
		@(posedge ref_clk_in) disable iff (!rst_b_in)
		$fell(hold_s) && ack_r |-> ack_r [*3];
	endproperty
	a_ack_hold: assert property (p_ack_hold) else $error("ack dropped early");
	property p_retake;
		@(posedge ref_clk_in) disable iff (!rst_b_in)
		$fell(ack_r) |-> ##[1:2] own_r;
	endproperty
	a_retake: assert property (p_retake) else $error("bus not retaken");
	property p_idle_before_ack;
		@(posedge ref_clk_in) disable iff (!rst_b_in)
		$rose(ack_r) |-> $past(lnk_idle_c, 2);
	endproperty
	a_idle_before_ack: assert property (p_idle_before_ack) else $error("ack mid transfer");
	property p_boff;
		@(posedge control_group_a_clock_in) disable iff (!rst_b_in)
		boff_l && lnk_r == xbm_pkg::XBM_LNK_DATA |=> lnk_r == xbm_pkg::XBM_LNK_IDLE && as_r;
	endproperty
	a_boff: assert property (p_boff) else $error("back-off ignored");
	property p_blast_idle;
		@(posedge control_group_a_clock_in) disable iff (!rst_b_in)
		lnk_r == xbm_pkg::XBM_LNK_IDLE |-> blast_r && wait_r;
	endproperty
	a_blast_idle: assert property (p_blast_idle) else $error("burst-last or wait low idle");
	property p_ready_in;
		@(posedge ref_clk_in) disable iff (!rst_b_in)
		!control_group_a_ready_n_oe_out;
	endproperty
	a_ready_in: assert property (p_ready_in) else $error("ready driven as master");
endmodule
`default_nettype wire

//--- tb/xbm_host_model.sv
// partner model: bus target that answers the master with an active-low ready
`default_nettype none
module xbm_host_model (
	// link clock and reset
	input wire logic control_group_a_clock_in,
	input wire logic rst_b_in,
	// pins seen from the far side
	input wire logic control_group_a_addr_strobe_n,
	input wire logic ctl_oe_in,
	input wire logic [3:0] wait_cyc_in,
	output logic control_group_a_ready_n
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [3:0] cnt_r;
	logic busy_r;
	logic [2:0] low_r;
	// a new strobe restarts the wait count, then ready is low four link cycles
	always_ff @(posedge control_group_a_clock_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			cnt_r <= 4'h0;
			busy_r <= 1'b0;
			low_r <= 3'h0;
		end else if (!control_group_a_addr_strobe_n && ctl_oe_in) begin
			cnt_r <= wait_cyc_in;
			busy_r <= 1'b1;
			low_r <= 3'h0;
		end else if (busy_r && cnt_r == 4'h0) begin
			busy_r <= 1'b0;
			low_r <= 3'h4;
		end else if (busy_r) begin
			cnt_r <= cnt_r - 4'h1;
		end else if (low_r != 3'h0) begin
			low_r <= low_r - 3'h1;
		end
	end
	// low means ready; a released line is pulled high
	assign control_group_a_ready_n = (low_r == 3'h0);
endmodule
`default_nettype wire

//--- tb/expansion_bus_master_arbitration_tb.sv
// testbench: transfers, back-off and hold arbitration of the bus master
`default_nettype none
module expansion_bus_master_arbitration_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic ref_clk_in = 0, rst_b_in = 0, control_group_a_clock_in = 0, strap = 1;
	logic req_in = 0, req_write_in = 0, req_last_in = 0, hold = 0, boff = 0;
	logic [3:0] req_be_in = 4'h0, wait_cyc = 4'h0, be_n;
	logic done, ack, as_n, dir, blast, oe, rdy_o, rdy_oe, wt, rdy_far;
	wire logic rdy_n = rdy_oe ? rdy_o : rdy_far;
	int errors = 0, compares = 0;
	// clocks: cpu 20 ns, link 30 ns with an unrelated phase
	always #10 ref_clk_in = ~ref_clk_in;
	initial begin
		#7;
		forever #15 control_group_a_clock_in = ~control_group_a_clock_in;
	end
	xbm_master dut_u (.ref_clk_in(ref_clk_in), .rst_b_in(rst_b_in),
		.control_group_a_clock_in(control_group_a_clock_in), .dir_pol_strap_in(strap), .req_in(req_in),
		.req_write_in(req_write_in), .req_be_in(req_be_in), .req_last_in(req_last_in),
		.req_done_out(done), .control_group_a_hold_request(hold), .control_group_a_hold_ack(ack),
		.control_group_a_byte_enable_n(be_n), .control_group_a_addr_strobe_n(as_n), .control_group_a_write_read_dir(dir),
		.control_group_a_burst_last(blast), .ctl_oe_out(oe), .control_group_a_ready_n_in(rdy_n),
		.control_group_a_ready_n_out(rdy_o), .control_group_a_ready_n_oe_out(rdy_oe), .control_group_a_wait_out(wt),
		.control_group_a_back_off(boff));
	xbm_host_model far_u (.control_group_a_clock_in(control_group_a_clock_in), .rst_b_in(rst_b_in),
		.control_group_a_addr_strobe_n(as_n), .ctl_oe_in(oe), .wait_cyc_in(wait_cyc),
		.control_group_a_ready_n(rdy_far));
	// verdict and end of run
	task automatic stop_test();
		$display("errors %0d compares %0d", errors, compares);
		if (errors == 0 && compares > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	task automatic chk(input string what, input logic [3:0] exp, input logic [3:0] got);
		compares++;
		if (got !== exp) begin
			errors++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic timeout(input string what);
		errors++;
		$display("Error %s expected completion seen timeout", what);
		stop_test();
	endtask
	// link-side wait for the address strobe, bounded
	task automatic wait_as();
		int i;
		i = 0;
		while (as_n !== 1'b0) begin
			i++;
			if (i > 60) timeout("addr_strobe");
			@(posedge control_group_a_clock_in);
			#1;
		end
	endtask
	// reset with a given strap; idle levels checked while held
	task automatic rst(input logic s);
		@(posedge ref_clk_in);
		#1;
		strap = s;
		rst_b_in = 0;
		repeat (3) @(posedge ref_clk_in);
		chk("reset_pins", 4'h7, {ack, oe, as_n, blast});
		chk("reset_be_n", 4'hF, be_n);
		chk("reset_wait", 4'h1, {3'h0, wt});
		#1;
		rst_b_in = 1;
		repeat (2) @(posedge ref_clk_in);
	endtask
	// one transfer; optional back-off during the data phase
	task automatic xfer(input logic w, input logic [3:0] be, input logic last,
		input logic [3:0] dly, input logic bo);
		int i;
		@(posedge ref_clk_in);
		#1;
		wait_cyc = dly;
		req_write_in = w;
		req_be_in = be;
		req_last_in = last;
		req_in = 1;
		wait_as();
		chk("byte_enable_n", ~be, be_n);
		chk("direction", {3'h0, strap ? w : ~w}, {3'h0, dir});
		chk("wait_out", 4'h1, {3'h0, wt});
		chk("ready_oe", 4'h0, {3'h0, rdy_oe});
		chk("ready_out", 4'h1, {3'h0, rdy_o});
		@(posedge control_group_a_clock_in);
		#1;
		chk("burst_last", {3'h0, ~last}, {3'h0, blast});
		if (bo) begin
			boff = 1;
			repeat (3) @(posedge control_group_a_clock_in);
			#1;
			boff = 0;
			wait_as(); // retried after back-off
			chk("retry_be_n", ~be, be_n);
		end
		i = 0;
		while (done !== 1'b1) begin
			i++;
			if (i > 300) timeout("req_done");
			@(posedge ref_clk_in);
			#1;
		end
		req_in = 0;
		repeat (8) @(posedge control_group_a_clock_in);
	endtask
	// hold handshake, optionally over a pending slow transfer
	task automatic arb(input logic px);
		int n;
		logic fin;
		fin = !px;
		@(posedge ref_clk_in);
		#1;
		if (px) begin
			wait_cyc = 4'h9;
			req_write_in = 1;
			req_be_in = 4'hF;
			req_last_in = 1;
			req_in = 1;
			wait_as();
			@(posedge ref_clk_in);
			#1;
		end
		hold = 1;
		n = 0;
		while (oe !== 1'b0) begin
			if (done === 1'b1) fin = 1;
			if (done === 1'b1) req_in = 0;
			if (ack !== 1'b0) chk("ack_early", 4'h0, {3'h0, ack});
			n++;
			if (n > 400) timeout("float");
			@(posedge ref_clk_in);
			#1;
		end
		chk("pending_done", 4'h1, {3'h0, fin});
		chk("float_min3", 4'h1, {3'h0, n >= 3});
		n = 0;
		while (ack !== 1'b1) begin
			n++;
			if (n > 10) timeout("ack");
			@(posedge ref_clk_in);
			#1;
		end
		chk("ack_within2", 4'h1, {3'h0, n <= 2 && oe === 1'b0});
		repeat (2) @(posedge ref_clk_in); // request kept past ack
		#1;
		hold = 0;
		n = 0;
		while (ack !== 1'b0) begin
			n++;
			if (n > 20) timeout("ack_drop");
			@(posedge ref_clk_in);
			#1;
		end
		chk("drop_min3", 4'h1, {3'h0, n >= 3});
		n = 0;
		while (oe !== 1'b1) begin
			n++;
			if (n > 10) timeout("redrive");
			@(posedge ref_clk_in);
			#1;
		end
		chk("redrive_within2", 4'h1, {3'h0, n <= 2});
		repeat (8) @(posedge control_group_a_clock_in);
	endtask
	initial begin
		#1000000;
		timeout("run");
	end
	initial begin
		rst(1'b1);
		xfer(1'b1, 4'h5, 1'b1, 4'h2, 1'b0);
		xfer(1'b0, 4'h8, 1'b0, 4'h0, 1'b0);
		xfer(1'b1, 4'h3, 1'b1, 4'h8, 1'b1);
		arb(1'b0);
		arb(1'b1);
		xfer(1'b0, 4'hC, 1'b1, 4'h1, 1'b0);
		rst(1'b0);
		xfer(1'b1, 4'hF, 1'b1, 4'h1, 1'b0);
		xfer(1'b0, 4'h1, 1'b0, 4'h3, 1'b0);
		stop_test();
	end
endmodule
`default_nettype wire
